/* File: logic/rsem_top.sv */
// Reconciliation error mapper between a MAC octet stream and the PHY pins.
module rsem_top
  import rsem_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   rx_clk_i,
  input  wire rsem_pkg::rsem_rx_pins_t rx_pins_i,
  output logic                        gtx_clk_o,
  output rsem_pkg::rsem_tx_pins_t     tx_pins_o,
  output rsem_pkg::rsem_mac_rx_t      mac_rx_o,
  input  wire rsem_pkg::rsem_mac_tx_t mac_tx_i,
  output logic                        mac_tx_ready_o
);
  import rsem_pkg::*;

  // Receive synchroniser state and frame tracking.
  logic          rx_clk_s1_reg;
  logic          rx_clk_s2_reg;
  logic          rx_clk_prev_reg;
  rsem_rx_pins_t rx_s1_reg;
  rsem_rx_pins_t rx_s2_reg;
  rsem_state_t   rx_st_reg;
  rsem_state_t   rx_st_next;
  logic          rx_err_reg;
  logic          rx_err_next;
  rsem_mac_rx_t  mac_rx_reg;
  rsem_mac_rx_t  mac_rx_next;
  logic          rx_rise;

  // Transmit divider, state and pin registers.
  logic [CNT_W-1:0] gtx_cnt_reg;
  logic [CNT_W-1:0] gtx_cnt_next;
  logic             gtx_clk_reg;
  logic             gtx_clk_next;
  logic             launch;
  rsem_state_t      tx_st_reg;
  rsem_state_t      tx_st_next;
  rsem_tx_pins_t    tx_pins_reg;
  rsem_tx_pins_t    tx_pins_next;
  logic             ready_reg;
  logic             ready_next;

  // Every pin from the PHY passes two flops; only the second is read, except that the clock also passes a third for its edge.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_clk_s1_reg   <= 1'b0;
      rx_clk_s2_reg   <= 1'b0;
      rx_clk_prev_reg <= 1'b0;
      rx_s1_reg       <= '0;
      rx_s2_reg       <= '0;
    end else begin
      rx_clk_s1_reg   <= rx_clk_i;
      rx_clk_s2_reg   <= rx_clk_s1_reg;
      rx_clk_prev_reg <= rx_clk_s2_reg;
      rx_s1_reg       <= rx_pins_i;
      rx_s2_reg       <= rx_s1_reg;
    end
  end

  // receive clock rise
  // The data pins are sampled where the synchronised clock shows a rise;
  // this assumes a link clock far slower than clk_i, as in the bench.
  assign rx_rise = rx_clk_s2_reg & ~rx_clk_prev_reg;

  // Receive next state: frame tracking and the error flag per frame.
  always_comb begin
    rx_st_next  = rx_st_reg;
    rx_err_next = rx_err_reg;
    mac_rx_next = '0;
    if (rx_rise) begin
      unique case (rx_st_reg)
        ST_IDLE: begin
          if (rx_s2_reg.dv) begin
            rx_st_next        = ST_FRAME;
            rx_err_next       = rx_s2_reg.er;
            mac_rx_next.valid = 1'b1;
            mac_rx_next.data  = rx_s2_reg.data;
          end
        end
        ST_FRAME: begin
          if (rx_s2_reg.dv) begin
            mac_rx_next.valid = 1'b1;
            mac_rx_next.data  = rx_s2_reg.data;
            if (rx_s2_reg.er) begin
              rx_err_next = 1'b1;
            end
          end else if (rx_s2_reg.er &&
                       (rx_s2_reg.data == CODE_EXTEND ||
                        rx_s2_reg.data == CODE_EXTEND_ERR)) begin
            rx_st_next = ST_EXT;
            if (rx_s2_reg.data == CODE_EXTEND_ERR) begin
              rx_err_next = 1'b1;
            end
          end else begin
            rx_st_next          = ST_IDLE;
            mac_rx_next.last    = 1'b1;
            mac_rx_next.fcs_err = rx_err_reg;
          end
        end
        ST_EXT: begin
          if (!rx_s2_reg.dv && rx_s2_reg.er) begin
            if (rx_s2_reg.data == CODE_EXTEND_ERR) begin
              rx_err_next = 1'b1;
            end
          end else begin
            rx_st_next          = ST_IDLE;
            mac_rx_next.last    = 1'b1;
            mac_rx_next.fcs_err = rx_err_reg;
          end
        end
        default: begin
          rx_st_next = ST_IDLE;
        end
      endcase
    end
  end

  // Receive registers.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_st_reg  <= ST_IDLE;
      rx_err_reg <= 1'b0;
      mac_rx_reg <= '0;
    end else begin
      rx_st_reg  <= rx_st_next;
      rx_err_reg <= rx_err_next;
      mac_rx_reg <= mac_rx_next;
    end
  end

  // Transmit clock divider; launch marks the cycle before its output rises.
  // launch on rise
  always_comb begin
    gtx_cnt_next = (gtx_cnt_reg == CNT_W'(GTX_PER_CYC - 1)) ?
                   '0 : gtx_cnt_reg + CNT_W'(1);
    launch       = (gtx_cnt_reg == CNT_W'(GTX_PER_CYC - 1));
    // The clock rises with the launch and falls half a period later, so
    // the first high phase after reset is as long as every later one.
    gtx_clk_next = gtx_clk_reg;
    if (launch) begin
      gtx_clk_next = 1'b1;
    end else if (gtx_cnt_reg == CNT_W'(GTX_HALF_CYC - 1)) begin
      gtx_clk_next = 1'b0;
    end
  end

  // Transmit next state. A MAC that stops supplying octets mid frame ends
  // the frame quietly; the PHY then sees a short frame, not a hang.
  always_comb begin
    tx_st_next   = tx_st_reg;
    tx_pins_next = tx_pins_reg;
    ready_next   = 1'b0;
    if (launch) begin
      tx_pins_next = '{en: 1'b0, er: 1'b0, data: OCTET_IDLE};
      if (tx_st_reg == ST_EXT) begin
        if (mac_tx_i.ext) begin
          tx_pins_next.er   = 1'b1;
          tx_pins_next.data = mac_tx_i.ext_err ? CODE_EXTEND_ERR : CODE_EXTEND;
        end else begin
          tx_st_next = ST_IDLE;
        end
      end else if (mac_tx_i.valid) begin
        ready_next        = 1'b1;
        tx_pins_next.en   = 1'b1;
        tx_pins_next.data = mac_tx_i.data;
        tx_pins_next.er   = mac_tx_i.err;
        if (!mac_tx_i.last) begin
          tx_st_next = ST_FRAME;
        end else if (mac_tx_i.ext) begin
          tx_st_next = ST_EXT;
        end else begin
          tx_st_next = ST_IDLE;
        end
      end else begin
        tx_st_next = ST_IDLE;
      end
    end
  end

  // Transmit registers; pins change only in the launch cycle.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      gtx_cnt_reg <= '0;
      gtx_clk_reg <= 1'b0;
      tx_st_reg   <= ST_IDLE;
      tx_pins_reg <= '0;
      ready_reg   <= 1'b0;
    end else begin
      gtx_cnt_reg <= gtx_cnt_next;
      gtx_clk_reg <= gtx_clk_next;
      tx_st_reg   <= tx_st_next;
      tx_pins_reg <= tx_pins_next;
      ready_reg   <= ready_next;
    end
  end

  assign gtx_clk_o      = gtx_clk_reg;
  assign tx_pins_o      = tx_pins_reg;
  assign mac_rx_o       = mac_rx_reg;
  assign mac_tx_ready_o = ready_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // Pins in extension: enable low and error high.
  sequence s_ext_now;
    !tx_pins_reg.en && tx_pins_reg.er;
  endsequence

  sequence s_gtx_rise;
    gtx_clk_reg && !$past(gtx_clk_reg);
  endsequence

  a_rx_frame_err: assert property (
    rx_rise && rx_st_reg == ST_FRAME && rx_s2_reg.dv && rx_s2_reg.er
    |=> rx_err_reg)
    else $error("In-frame error not kept for the frame.");

  a_rx_err_hold: assert property (
    rx_err_reg && rx_st_reg != ST_IDLE |=> rx_err_reg)
    else $error("Frame error flag lost before the frame ended.");

  a_rx_ext_err: assert property (
    rx_rise && rx_st_reg == ST_EXT && !rx_s2_reg.dv && rx_s2_reg.er &&
    rx_s2_reg.data == CODE_EXTEND_ERR |=> rx_err_reg)
    else $error("Extend error not recorded.");

  a_rx_end_flag: assert property (
    mac_rx_reg.last |-> mac_rx_reg.fcs_err == $past(rx_err_reg))
    else $error("Frame end reports wrong check error.");

  a_rx_ext_enter: assert property (
    rx_st_reg == ST_FRAME ##1 rx_st_reg == ST_EXT
    |-> $past(rx_s2_reg.er) && !$past(rx_s2_reg.dv))
    else $error("Extension entered without valid low and error high.");

  a_tx_err_frame: assert property (
    tx_pins_reg.en && ready_reg |-> tx_pins_reg.er == $past(mac_tx_i.err))
    else $error("Transmit error line differs from the MAC request.");

  a_tx_ext_start: assert property (
    s_ext_now |-> $past(tx_pins_reg.en) || $past(tx_pins_reg.er))
    else $error("Extension not directly after a frame octet.");

  a_tx_ext_code: assert property (
    s_ext_now |-> tx_pins_reg.data == CODE_EXTEND ||
                 tx_pins_reg.data == CODE_EXTEND_ERR)
    else $error("Extension octet carries a wrong code.");

  a_tx_launch: assert property (
    tx_pins_reg != $past(tx_pins_reg) |-> s_gtx_rise)
    else $error("Transmit pins changed away from a clock rise.");

  a_gtx_shape: assert property (
    s_gtx_rise |-> gtx_clk_reg [*4] ##1 !gtx_clk_reg [*4])
    else $error("Transmit clock shape is wrong.");
endmodule // rsem_top

/* File: logic/rsem_pkg.sv */
// Package with constants and carrier types for the octet-link error mapper.
package rsem_pkg;
  // Clock rates and the transmit link clock made by division.
  localparam int CLK_PERIOD_NS = 100;
  localparam int GTX_PERIOD_NS = 800;
  localparam int GTX_PER_CYC   = GTX_PERIOD_NS / CLK_PERIOD_NS;
  localparam int GTX_HALF_CYC  = GTX_PER_CYC / 2;
  localparam int CNT_W         = $clog2(GTX_PER_CYC);

  // Octet values sent while enable is low: the extension codes with the error line high, idle with it low.
  localparam logic [7:0] CODE_EXTEND     = 8'h0f;
  localparam logic [7:0] CODE_EXTEND_ERR = 8'h1f;
  localparam logic [7:0] OCTET_IDLE      = 8'h00;

  // Pin groups towards the physical layer device.
  typedef struct packed {
    logic       dv;
    logic       er;
    logic [7:0] data;
  } rsem_rx_pins_t;

  typedef struct packed {
    logic       en;
    logic       er;
    logic [7:0] data;
  } rsem_tx_pins_t;

  // Octet stream towards the MAC on receive.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic       fcs_err;
  } rsem_mac_rx_t;

  // Octet request from the MAC on transmit.
  typedef struct packed {
    logic       valid;
    logic       last;
    logic       err;
    logic       ext;
    logic       ext_err;
    logic [7:0] data;
  } rsem_mac_tx_t;

  // Link states, Gray coded along idle, frame, extension.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_FRAME = 2'h1,
    ST_EXT   = 2'h3
  } rsem_state_t;
endpackage

/* File: dv/rsem_phy_model.sv */
// Behavioural link partner: drives receive pins, records transmit pins.
module rsem_phy_model (
  input  wire logic                    clk_i,
  input  wire logic                    gtx_clk_i,
  input  wire rsem_pkg::rsem_tx_pins_t tx_pins_i,
  output logic                         rx_clk_o,
  output rsem_pkg::rsem_rx_pins_t      rx_pins_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import rsem_pkg::*;

  rsem_tx_pins_t txq[$];
  int            n_bad = 0;

  // The link clock stands still outside frames.
  initial begin
    rx_clk_o  = 1'b0;
    rx_pins_o = '0;
  end

  // extension is dv low, er high
  // Pins change on the clock fall so they hold half a period round a rise.
  task automatic put(input logic dv, input logic er, input logic [7:0] d);
    rx_pins_o = '{dv, er, d};
    repeat (4) @(negedge clk_i);
    rx_clk_o = 1'b1;
    repeat (4) @(negedge clk_i);
    rx_clk_o = 1'b0;
  endtask

  // The released bus drops valid and error and flips the data, so a stale octet never reads as valid.
  task automatic rest();
    rx_pins_o = '{1'b0, 1'b0, ~rx_pins_o.data};
  endtask

  // errored octet is invalid code-group
  // Sampled mid-period, since the pins move with the clock rise; an octet
  // sent with enable and error both high leaves as an invalid code-group.
  always @(negedge gtx_clk_i) begin
    if (tx_pins_i.en || tx_pins_i.er)
      txq.push_back(tx_pins_i);
    if (tx_pins_i.en && tx_pins_i.er)
      n_bad++;
  end
endmodule // rsem_phy_model

/* File: dv/tb_rsem_top.sv */
// Self-checking bench for the octet-link error mapper.
module tb_rsem_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rsem_pkg::*;

  logic          clk_i;
  logic          sys_rst_i;
  logic          rx_clk;
  logic          gtx_clk;
  logic          tx_ready;
  rsem_rx_pins_t rx_pins;
  rsem_tx_pins_t tx_pins;
  rsem_mac_rx_t  mac_rx;
  rsem_mac_tx_t  mac_tx;
  logic [7:0]    rxq[$];
  logic          endq[$];
  int            n_errors = 0;
  int            cmp_count = 0;

  rsem_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .rx_clk_i(rx_clk),
    .rx_pins_i(rx_pins), .gtx_clk_o(gtx_clk), .tx_pins_o(tx_pins),
    .mac_rx_o(mac_rx), .mac_tx_i(mac_tx), .mac_tx_ready_o(tx_ready));

  rsem_phy_model i_phy (.clk_i(clk_i), .gtx_clk_i(gtx_clk),
    .tx_pins_i(tx_pins), .rx_clk_o(rx_clk), .rx_pins_o(rx_pins));

  // The clock runs at 10 MHz.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Received octets and frame ends, each pulse seen once, mid-cycle.
  always @(negedge clk_i) begin
    if (mac_rx.valid === 1'b1)
      rxq.push_back(mac_rx.data);
    if (mac_rx.last === 1'b1)
      endq.push_back(mac_rx.fcs_err);
  end

  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_tx(input rsem_tx_pins_t got, input rsem_tx_pins_t exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Counts octets, then checks the one frame-end flag and clears.
  task automatic rx_done(input logic [15:0] n, input logic f);
    repeat (8) @(negedge clk_i);
    chk_v(16'(rxq.size()), n);
    chk_v(16'(endq.size()), 16'h1);
    chk_v({15'h0, endq[0]}, {15'h0, f});
    rxq.delete();
    endq.delete();
  endtask

  task automatic rx_good();
    i_phy.put(1'b1, 1'b0, 8'h55);
    i_phy.put(1'b1, 1'b0, 8'hd5);
    i_phy.put(1'b0, 1'b1, CODE_EXTEND);
    i_phy.put(1'b0, 1'b0, 8'h00);
    i_phy.rest();
    chk_v({8'h0, rxq[0]}, 16'h55);
    chk_v({8'h0, rxq[1]}, 16'hd5);
    rx_done(16'h2, 1'b0);
  endtask

  task automatic rx_err();
    i_phy.put(1'b1, 1'b0, 8'h11);
    i_phy.put(1'b1, 1'b1, 8'h22);
    i_phy.put(1'b1, 1'b0, 8'h33);
    i_phy.put(1'b0, 1'b0, 8'h00);
    i_phy.rest();
    rx_done(16'h3, 1'b1);
  endtask

  task automatic rx_ext();
    i_phy.put(1'b1, 1'b0, 8'h44);
    i_phy.put(1'b0, 1'b1, CODE_EXTEND);
    i_phy.put(1'b0, 1'b1, CODE_EXTEND_ERR);
    i_phy.put(1'b0, 1'b0, 8'h00);
    i_phy.rest();
    rx_done(16'h1, 1'b1);
  endtask

  // Holds the request until ready shows it was taken.
  task automatic tx_put(input rsem_mac_tx_t r);
    int k;
    mac_tx = r;
    for (k = 0; k < 20; k++) begin
      @(negedge clk_i);
      if (tx_ready === 1'b1)
        break;
    end
    chk_v(16'(k < 20), 16'h1);
  endtask

  task automatic tx_frame();
    mac_tx = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00};
    repeat (24) @(negedge clk_i);
    chk_v(16'(i_phy.txq.size()), 16'h0);
    tx_put('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h12});
    tx_put('{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h34});
    tx_put('{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 8'h56});
    mac_tx = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00};
    repeat (8) @(negedge clk_i);
    mac_tx = '0;
    repeat (24) @(negedge clk_i);
    chk_tx(i_phy.txq[0], '{1'b1, 1'b0, 8'h12});
    chk_tx(i_phy.txq[1], '{1'b1, 1'b1, 8'h34});
    chk_tx(i_phy.txq[2], '{1'b1, 1'b0, 8'h56});
    chk_tx(i_phy.txq[3], '{1'b0, 1'b1, CODE_EXTEND_ERR});
    chk_v(16'(i_phy.txq.size()), 16'h4);
    chk_v(16'(i_phy.n_bad), 16'h1);
  endtask

  // Single-octet frame with a clean extension, then the pins go idle.
  task automatic tx_plain();
    i_phy.txq.delete();
    tx_put('{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 8'h78});
    mac_tx = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00};
    repeat (8) @(negedge clk_i);
    mac_tx = '0;
    repeat (24) @(negedge clk_i);
    chk_v(16'(i_phy.txq.size()), 16'h2);
    chk_tx(i_phy.txq[0], '{1'b1, 1'b0, 8'h78});
    chk_tx(i_phy.txq[1], '{1'b0, 1'b1, CODE_EXTEND});
  endtask

  task automatic stop_test();
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // A hang is cut short well beyond the few hundred cycles expected.
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end

  initial begin
    sys_rst_i = 1'b1;
    mac_tx = '0;
    repeat (6) @(negedge clk_i);
    sys_rst_i = 1'b0;
    rx_good();
    rx_err();
    rx_ext();
    tx_frame();
    tx_plain();
    stop_test();
  end
endmodule // tb_rsem_top
